/* File: rtl/cse_pkg.sv */
// Package of register map, field positions and timing constants for the card event unit
package cse_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_PRIMARY_STATUS   = 8'h00;
  localparam logic [7:0] OFF_SECONDARY_STATUS = 8'h04;
  localparam logic [7:0] OFF_EVENT_MASK       = 8'h08;
  localparam logic [7:0] OFF_FIFO_SETUP       = 8'h0C;
  localparam logic [7:0] OFF_RESP_WAIT_LIMIT  = 8'h10;
  localparam logic [7:0] OFF_BLOCK_COUNT      = 8'h14;
  localparam logic [7:0] OFF_BLOCKS_REMAINING = 8'h18;
  localparam logic [7:0] OFF_RECEIVE_PORT     = 8'h1C;
  localparam logic [7:0] OFF_TRANSMIT_PORT    = 8'h20;
  localparam logic [7:0] OFF_COMMAND_ISSUE    = 8'h24;

  // ****************************************************************
  // Primary event status bit positions
  // ****************************************************************
  localparam int EV_DATA_DONE   = 0;
  localparam int EV_BUSY_DONE   = 1;
  localparam int EV_RESP_DONE   = 2;
  localparam int EV_TOUT_READ   = 3;
  localparam int EV_TOUT_RESP   = 4;
  localparam int EV_CRC_WRITE   = 5;
  localparam int EV_CRC_READ    = 6;
  localparam int EV_CRC_RESP    = 7;
  localparam int EV_TX_READY    = 9;
  localparam int EV_RX_READY    = 10;
  localparam int EV_DAT3_EDGE   = 11;
  localparam int EV_LAST_MOVED  = 12;
  localparam int EV_COUNT       = 13;
  localparam logic [12:0] EV_USED_MASK = 13'h1EFF;

  // ****************************************************************
  // Secondary status bit positions
  // ****************************************************************
  localparam int ST_BUSY        = 0;
  localparam int ST_CLK_HALTED  = 1;
  localparam int ST_RX_FULL     = 2;
  localparam int ST_TX_EMPTY    = 3;

  // ****************************************************************
  // Field positions of setup registers
  // ****************************************************************
  localparam int FS_THRESH_512  = 2;
  localparam int CI_RESP_EXP    = 0;
  localparam int CI_BUSY_EXP    = 1;
  localparam int CI_WRITE_DIR   = 2;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [12:0] MASK_RESET    = 13'h0000;
  localparam logic [7:0]  WAIT_RESET    = 8'h00;
  localparam logic [15:0] BLOCKS_RESET  = 16'h0000;
  localparam int          FIFO_AW       = 4;
  localparam logic [4:0]  LEVEL_256     = 5'h08;
  localparam logic [4:0]  LEVEL_512     = 5'h10;
  localparam int          ID_SILENCE_CLKS = 5;

endpackage

/* File: rtl/cse_sync.sv */
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
module cse_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // Function clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic [W-1:0] d_i,    // Asynchronous input
  output logic      [W-1:0] q_o     // Synchronised output
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

/* File: rtl/cse_fifo_mem.sv */
// Small data memory with registered read port for the transfer FIFO
`timescale 1ns/1ps
module cse_fifo_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input  wire logic          clk_i,  // Function clock
  input  wire logic          we_i,   // Write enable
  input  wire logic [AW-1:0] wa_i,   // Write address
  input  wire logic [DW-1:0] wd_i,   // Write data
  input  wire logic [AW-1:0] ra_i,   // Read address
  output logic      [DW-1:0] rd_o    // Registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem[wa_i] <= wd_i;
    rd_o <= mem[ra_i];
  end
endmodule

/* File: rtl/cse_event_unit.sv */
// Status, interrupt, FIFO-threshold and DMA event unit of a card host controller
//
// Notes on behaviour
// RQ1 - Read-only receive-shifter-full status bit, no interrupt attached.
// RQ2 - Secondary status shows whether the card clock is halted.
// RQ3 - Read-only counter reports blocks still remaining in a multi-block transfer.
// RQ4 - Events set status flags; interrupt only when mask bit enabled.
// RQ5 - All enabled events OR into one interrupt output, nothing else.
// RQ6 - Any read of primary status clears all its flags.
// RQ7 - Ready flags fire once per 256 or 512 bits per threshold setting.
// RQ8 - Data port access clears the matching ready flag and interrupt.
// RQ9 - Transfer-done on last read byte before CRC, or last word to shifter; the unit raises it on each word taken while blocks_left is 1.
// RQ10 - Any transition on card data line 3 raises an edge event.
// RQ11 - Receive-ready above threshold, transmit-ready below threshold.
// RQ12 - Separate CRC error events for response, read data, write data.
// RQ13 - Separate time-outs for command response and read data.
// RQ14 - Response-done on clean response, or after sending no-response command.
// RQ15 - Busy-done when card stops or never sends busy while expected.
// RQ16 - Data-done on clean read data, or when write data is sent.
// RQ17 - DMA request each 256 or 512 bits moved through the FIFO.
// RQ18 - Debug halt events are ignored; operation continues.
// RQ19 - Host sets card mode and 400 kHz or slower clock, open drain.
// RQ20 - MMC identify: CMD0, CMD1 while busy, then CMD2/CMD3 loop.
// RQ21 - SD identify: CMD0, CMD55, ACMD41, then CMD2/CMD3 loop.
// RQ22 - No answer within 5 card clocks ends identification.
// RQ23 - Wait limit zero waits forever; else time out after that many clocks.
// RQ24 - Event coinciding with clearing read stays set.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module cse_event_unit #(
  parameter int DW = 32
) (
  input  wire logic          clk_i,          // Function clock, 50 MHz
  input  wire logic          rst_i,          // Synchronous reset, active high
  input  wire logic          wb_cyc_i,       // Wishbone cycle
  input  wire logic          wb_stb_i,       // Wishbone strobe
  input  wire logic          wb_we_i,        // Wishbone write enable
  input  wire logic [7:0]    wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]    wb_sel_i,       // Wishbone byte selects
  input  wire logic [DW-1:0] wb_dat_i,       // Wishbone write data
  output logic      [DW-1:0] wb_dat_o,       // Wishbone read data
  output logic               wb_ack_o,       // Wishbone acknowledge
  input  wire logic          card_clock_pin_i,  // Card clock as seen on the pin
  input  wire logic          card_data3_pin_i,  // Card data line 3 pin
  input  wire logic          rx_bit_valid_i, // Receive shifter accepted a bit
  input  wire logic          rx_word_i,      // Receive shifter delivers a word
  input  wire logic [DW-1:0] rx_data_i,      // Word from receive shifter
  input  wire logic          rx_last_byte_i, // Last read byte received
  input  wire logic          tx_take_i,      // Transmit shifter takes a word
  input  wire logic          resp_end_i,     // Response received
  input  wire logic          resp_crc_bad_i, // Response CRC error
  input  wire logic          cmd_sent_i,     // Command fully sent
  input  wire logic          card_busy_i,    // Card signals busy
  input  wire logic          read_end_i,     // Read data block ended
  input  wire logic          read_crc_bad_i, // Read data CRC error
  input  wire logic          write_end_i,    // Write data sent
  input  wire logic          write_crc_bad_i,// Write CRC status error
  input  wire logic          read_tout_i,    // Read data wait expired
  input  wire logic          clk_halted_i,   // Card clock stopped by divider
  output logic               irq_o,          // Single interrupt request
  output logic               dma_req_o,      // DMA service pulse
  output logic               tx_empty_o      // Transmit shifter has no word
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    WAIT_IDLE = 2'b00,
    WAIT_RESP = 2'b01,
    WAIT_BUSY = 2'b10
  } cse_wait_t;

  typedef struct packed {
    logic [12:0]          status;
    logic [12:0]          mask;
    logic [2:0]           fifo_setup;
    logic [7:0]           wait_limit;
    logic [15:0]          blocks_left;
    logic [2:0]           cmd_flags;
    cse_wait_t            wst;
    logic [7:0]           wait_cnt;
    logic                 busy_seen;
    logic                 clk_d;
    logic                 d3_d;
    logic [4:0]           level;
    logic [4:0]           moved;
    logic [3:0]           wptr;
    logic [3:0]           rptr;
    logic                 rx_full;
    logic [DW-1:0]        dat;
    logic                 ack;
    logic                 irq;
    logic                 dma;
    logic                 tx_empty;
  } cse_state_t;

  cse_state_t st_r;
  cse_state_t st_nxt;

  logic          clk_s;
  logic          d3_s;
  logic [DW-1:0] mem_rd;
  logic          mem_we;
  logic [3:0]    mem_wa;
  logic [DW-1:0] mem_wd;

  // ****************************************************************
  // Pin synchronisers and FIFO store
  // ****************************************************************
  cse_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({card_clock_pin_i, card_data3_pin_i}),
    .q_o   ({clk_s, d3_s})
  );

  cse_fifo_mem #(.AW(cse_pkg::FIFO_AW), .DW(DW)) u_mem (
    .clk_i (clk_i),
    .we_i  (mem_we),
    .wa_i  (mem_wa),
    .wd_i  (mem_wd),
    .ra_i  (st_nxt.rptr),
    .rd_o  (mem_rd)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic          req;
    logic          rd_stat;
    logic          wr;
    logic          card_edge;
    logic          rx_dir;
    logic          port_rd;
    logic          port_wr;
    logic [4:0]    thr;
    logic [12:0]   ev;
    req       = 1'b0;
    rd_stat   = 1'b0;
    wr        = 1'b0;
    card_edge = 1'b0;
    rx_dir    = 1'b0;
    port_rd   = 1'b0;
    port_wr   = 1'b0;
    thr       = 5'h00;
    ev        = 13'h0000;
    st_nxt    = st_r;
    mem_we    = 1'b0;
    mem_wa    = st_r.wptr;
    mem_wd    = wb_dat_i;

    // Bus slave: one wait state, ack dropped in the cycle after it was given
    req          = wb_cyc_i && wb_stb_i && !st_r.ack;
    wr           = req && wb_we_i && (wb_sel_i == 4'hF);
    rd_stat      = req && !wb_we_i && (wb_adr_i == cse_pkg::OFF_PRIMARY_STATUS);
    st_nxt.ack   = req;
    st_nxt.dma   = 1'b0;
    rx_dir       = !st_r.cmd_flags[cse_pkg::CI_WRITE_DIR];
    port_rd      = req && !wb_we_i && (wb_adr_i == cse_pkg::OFF_RECEIVE_PORT);
    port_wr      = wr && (wb_adr_i == cse_pkg::OFF_TRANSMIT_PORT);
    thr          = st_r.fifo_setup[cse_pkg::FS_THRESH_512] ? cse_pkg::LEVEL_512
                                                           : cse_pkg::LEVEL_256;

    // Card clock edge finder, only for counting card clock cycles
    st_nxt.clk_d = clk_s;
    card_edge    = clk_s && !st_r.clk_d;
    st_nxt.d3_d  = d3_s;
    ev[cse_pkg::EV_DAT3_EDGE] = d3_s ^ st_r.d3_d;                  // [RQ10]

    // FIFO data movement, one word per cycle at most
    if (rx_dir && rx_word_i && st_r.level != 5'h10)
    begin
      mem_we        = 1'b1;
      mem_wd        = rx_data_i;
      st_nxt.wptr   = st_r.wptr + 4'h1;
      st_nxt.level  = st_r.level + 5'h01;
      st_nxt.moved  = st_r.moved + 5'h01;
    end
    else if (!rx_dir && port_wr && st_r.level != 5'h10)
    begin
      mem_we        = 1'b1;
      st_nxt.wptr   = st_r.wptr + 4'h1;
      st_nxt.level  = st_r.level + 5'h01;
    end
    else if ((rx_dir && port_rd) || (!rx_dir && tx_take_i))
    begin
      if (st_r.level != 5'h00)
      begin
        st_nxt.rptr  = st_r.rptr + 4'h1;
        st_nxt.level = st_r.level - 5'h01;
        if (!rx_dir)
          st_nxt.moved = st_r.moved + 5'h01;
      end
    end
    st_nxt.tx_empty = !rx_dir && (st_nxt.level == 5'h00);
    st_nxt.rx_full  = rx_dir && (st_nxt.level == 5'h10) && (rx_bit_valid_i || st_r.rx_full);  // [RQ1]

    // Threshold quantum reached: ready flag and DMA pulse
    if (st_nxt.moved >= thr)                                        // [RQ7]
    begin
      st_nxt.moved = 5'h00;
      st_nxt.dma   = 1'b1;                                          // [RQ17]
      if (rx_dir && st_nxt.level > thr - 5'h01)                     // [RQ11]
        ev[cse_pkg::EV_RX_READY] = 1'b1;
      if (!rx_dir && st_nxt.level < thr)                            // [RQ11]
        ev[cse_pkg::EV_TX_READY] = 1'b1;
    end

    ev[cse_pkg::EV_LAST_MOVED] = rx_dir ? rx_last_byte_i           // [RQ9]
                                        : (tx_take_i && st_r.blocks_left == 16'h0001);
    ev[cse_pkg::EV_CRC_RESP]   = resp_end_i && resp_crc_bad_i;      // [RQ12]
    ev[cse_pkg::EV_CRC_READ]   = read_end_i && read_crc_bad_i;      // [RQ12]
    ev[cse_pkg::EV_CRC_WRITE]  = write_crc_bad_i;                   // [RQ12]
    ev[cse_pkg::EV_TOUT_READ]  = read_tout_i;                       // [RQ13]
    ev[cse_pkg::EV_DATA_DONE]  = (read_end_i && !read_crc_bad_i) || write_end_i;  // [RQ16]

    // Block countdown
    if ((read_end_i || write_end_i) && st_r.blocks_left != 16'h0000)
      st_nxt.blocks_left = st_r.blocks_left - 16'h0001;             // [RQ3]

    // Response / busy wait sequencer
    case (st_r.wst)
      WAIT_IDLE:
      begin
        if (cmd_sent_i)
        begin
          st_nxt.wait_cnt = 8'h00;
          if (st_r.cmd_flags[cse_pkg::CI_RESP_EXP])
            st_nxt.wst = WAIT_RESP;
          else
          begin
            ev[cse_pkg::EV_RESP_DONE] = 1'b1;                       // [RQ14]
            if (st_r.cmd_flags[cse_pkg::CI_BUSY_EXP])
            begin
              st_nxt.wst       = WAIT_BUSY;
              st_nxt.busy_seen = 1'b0;
            end
          end
        end
      end
      WAIT_RESP:
      begin
        if (resp_end_i)
        begin
          ev[cse_pkg::EV_RESP_DONE] = !resp_crc_bad_i;              // [RQ14]
          st_nxt.busy_seen = 1'b0;
          st_nxt.wst = st_r.cmd_flags[cse_pkg::CI_BUSY_EXP] ? WAIT_BUSY : WAIT_IDLE;
        end
        else if (card_edge && st_r.wait_limit != 8'h00)             // [RQ23]
        begin
          st_nxt.wait_cnt = st_r.wait_cnt + 8'h01;
          if (st_nxt.wait_cnt == st_r.wait_limit)                   // [RQ22]
          begin
            ev[cse_pkg::EV_TOUT_RESP] = 1'b1;                       // [RQ13]
            st_nxt.wst = WAIT_IDLE;
          end
        end
      end
      WAIT_BUSY:
      begin
        if (card_busy_i)
          st_nxt.busy_seen = 1'b1;
        else
        begin
          ev[cse_pkg::EV_BUSY_DONE] = 1'b1;                         // [RQ15]
          st_nxt.wst = WAIT_IDLE;
        end
      end
      default:
        st_nxt.wst = WAIT_IDLE;
    endcase

    // Register writes
    if (wr)
    begin
      if (wb_adr_i == cse_pkg::OFF_EVENT_MASK)
        st_nxt.mask = wb_dat_i[12:0] & cse_pkg::EV_USED_MASK;
      else if (wb_adr_i == cse_pkg::OFF_FIFO_SETUP)
      begin
        st_nxt.fifo_setup = wb_dat_i[2:0];
        st_nxt.wptr = 4'h0;
        st_nxt.rptr = 4'h0;
        st_nxt.level = 5'h00;
        st_nxt.moved = 5'h00;
        ev[cse_pkg::EV_TX_READY] = !rx_dir;                         // [RQ11]
      end
      else if (wb_adr_i == cse_pkg::OFF_RESP_WAIT_LIMIT)
        st_nxt.wait_limit = wb_dat_i[7:0];
      else if (wb_adr_i == cse_pkg::OFF_BLOCK_COUNT)
        st_nxt.blocks_left = wb_dat_i[15:0];
      else if (wb_adr_i == cse_pkg::OFF_COMMAND_ISSUE)
        st_nxt.cmd_flags = wb_dat_i[2:0];
    end

    // Status flags: clear on read, port access clears ready, set wins
    if (rd_stat)
      st_nxt.status = 13'h0000;                                     // [RQ6]
    if (port_rd)
      st_nxt.status[cse_pkg::EV_RX_READY] = 1'b0;                   // [RQ8]
    if (port_wr)
      st_nxt.status[cse_pkg::EV_TX_READY] = 1'b0;                   // [RQ8]
    st_nxt.status = st_nxt.status | ev;                             // [RQ4] [RQ24]

    // Read data
    st_nxt.dat = '0;
    if (req && !wb_we_i)
    begin
      if (wb_adr_i == cse_pkg::OFF_PRIMARY_STATUS)
        st_nxt.dat[12:0] = st_r.status;
      else if (wb_adr_i == cse_pkg::OFF_SECONDARY_STATUS)
      begin
        st_nxt.dat[cse_pkg::ST_BUSY]       = card_busy_i;
        st_nxt.dat[cse_pkg::ST_CLK_HALTED] = clk_halted_i;          // [RQ2]
        st_nxt.dat[cse_pkg::ST_RX_FULL]    = st_r.rx_full;          // [RQ1]
        st_nxt.dat[cse_pkg::ST_TX_EMPTY]   = st_r.tx_empty;
      end
      else if (wb_adr_i == cse_pkg::OFF_EVENT_MASK)
        st_nxt.dat[12:0] = st_r.mask;
      else if (wb_adr_i == cse_pkg::OFF_FIFO_SETUP)
        st_nxt.dat[2:0] = st_r.fifo_setup;
      else if (wb_adr_i == cse_pkg::OFF_RESP_WAIT_LIMIT)
        st_nxt.dat[7:0] = st_r.wait_limit;
      else if (wb_adr_i == cse_pkg::OFF_BLOCKS_REMAINING)
        st_nxt.dat[15:0] = st_r.blocks_left;                        // [RQ3]
      else if (wb_adr_i == cse_pkg::OFF_RECEIVE_PORT)
        st_nxt.dat = mem_rd;
      else if (wb_adr_i == cse_pkg::OFF_COMMAND_ISSUE)
        st_nxt.dat[2:0] = st_r.cmd_flags;
    end

    // No debug halt input exists: the unit never freezes
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);                    // [RQ5] [RQ18]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r            <= '0;
      st_r.mask       <= cse_pkg::MASK_RESET;
      st_r.wait_limit <= cse_pkg::WAIT_RESET;
      st_r.blocks_left <= cse_pkg::BLOCKS_RESET;
      st_r.wst        <= WAIT_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign wb_dat_o   = st_r.dat;
  assign wb_ack_o   = st_r.ack;
  assign irq_o      = st_r.irq;
  assign dma_req_o  = st_r.dma;
  assign tx_empty_o = st_r.tx_empty;

endmodule

/* File: dv/cse_event_unit_props.sv */
// Checker of bus, interrupt and DMA timing of the card event unit
`timescale 1ns/1ps
module cse_event_unit_props (
  input wire logic        clk_i,            // Clock
  input wire logic        rst_i,            // Reset
  input wire logic        wb_cyc_i,         // Cycle
  input wire logic        wb_stb_i,         // Strobe
  input wire logic        wb_we_i,          // Write
  input wire logic [7:0]  wb_adr_i,         // Address
  input wire logic [3:0]  wb_sel_i,         // Selects
  input wire logic [31:0] wb_dat_i,         // Write data
  input wire logic [31:0] wb_dat_o,         // Read data
  input wire logic        wb_ack_o,         // Acknowledge
  input wire logic        card_data3_pin_i, // Data line 3
  input wire logic        read_tout_i,      // Read time-out
  input wire logic        write_crc_bad_i,  // Write CRC error
  input wire logic        irq_o,            // Interrupt
  input wire logic        dma_req_o,        // DMA pulse
  input wire logic        tx_empty_o        // Transmit empty
);
  // ****************************************************************
  // Mask copy as written over the bus
  // ****************************************************************
  logic [12:0] mask_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_r <= cse_pkg::MASK_RESET;
    else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i == 4'hF
             && wb_adr_i == cse_pkg::OFF_EVENT_MASK)
      mask_r <= wb_dat_i[12:0];
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_outputs_low: assert property (disable iff (1'b0) rst_i |=> !irq_o && !dma_req_o && !tx_empty_o)
    else $error("outputs active after reset");
  a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mask_zero_quiet: assert property (mask_r == 13'h0 && $past(mask_r) == 13'h0 |-> !irq_o)
    else $error("interrupt with all events masked");
  a_read_tout_irq: assert property (mask_r[cse_pkg::EV_TOUT_READ] && read_tout_i |-> ##[1:2] irq_o)
    else $error("read time-out gave no interrupt");
  a_write_crc_irq: assert property (mask_r[cse_pkg::EV_CRC_WRITE] && write_crc_bad_i |-> ##[1:2] irq_o)
    else $error("write CRC error gave no interrupt");
  a_dat3_edge_irq: assert property (mask_r[cse_pkg::EV_DAT3_EDGE] && $changed(card_data3_pin_i)
    |-> ##[1:6] irq_o)
    else $error("data line 3 edge gave no interrupt");
  a_dma_quantum_gap: assert property (dma_req_o |=> !dma_req_o [*7])
    else $error("DMA pulses closer than a quantum");
  cover property (irq_o);
  cover property (dma_req_o);
  cover property (wb_ack_o && !wb_we_i && wb_adr_i == cse_pkg::OFF_PRIMARY_STATUS);
endmodule

bind cse_event_unit cse_event_unit_props props_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .card_data3_pin_i(card_data3_pin_i), .read_tout_i(read_tout_i),
  .write_crc_bad_i(write_crc_bad_i), .irq_o(irq_o), .dma_req_o(dma_req_o), .tx_empty_o(tx_empty_o));

/* File: dv/cse_card_model.sv */
// Card-side model of the card clock and data line 3 pins
`timescale 1ns/1ps
module cse_card_model (
  input  wire logic run_i,  // Clock runs inside a frame
  input  wire logic dat3_i, // Level the card puts on data line 3
  output logic      clk_o,  // Card clock pin
  output logic      dat3_o  // Data line 3 pin
);
  // Clock of 160 ns, still outside frames; the card never answers a command
  initial
  begin
    clk_o = 1'b0;
    #7;
    forever
    begin
      #80;
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
  assign dat3_o = dat3_i;
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the card event unit
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, dma, txe, cclk, cd3;
  logic        run = 1'b0, d3 = 1'b0, busy = 1'b0, halt = 1'b0, rbv = 1'b0, rxw = 1'b0, txt = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [8:0]  ev = 9'h000;
  logic [31:0] wdat = 32'h0, rxd = 32'h0, dout, rdat, r1;
  int          n_errors = 0, cmp_count = 0, n_dma = 0, k;
  logic [2:0]  tc [9] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h4, 3'h1, 3'h1};
  logic [8:0]  tv [9] = '{9'h021, 9'h0C0, 9'h030, 9'h080, 9'h020, 9'h018, 9'h004, 9'h002, 9'h100};
  logic [12:0] ts [9] = '{13'h8, 13'h80, 13'h1, 13'h4, 13'h4, 13'h40, 13'h1, 13'h20, 13'h1000};
  logic [12:0] tn [9] = '{13'h4, 13'h4, 13'h4, 13'h0, 13'h0, 13'h1, 13'h0, 13'h0, 13'h0};
  cse_event_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .card_clock_pin_i(cclk),
    .card_data3_pin_i(cd3), .rx_bit_valid_i(rbv), .rx_word_i(rxw), .rx_data_i(rxd), .rx_last_byte_i(ev[8]),
    .tx_take_i(txt), .resp_end_i(ev[7]), .resp_crc_bad_i(ev[6]), .cmd_sent_i(ev[5]), .card_busy_i(busy),
    .read_end_i(ev[4]), .read_crc_bad_i(ev[3]), .write_end_i(ev[2]), .write_crc_bad_i(ev[1]),
    .read_tout_i(ev[0]), .clk_halted_i(halt), .irq_o(irq), .dma_req_o(dma), .tx_empty_o(txe));
  cse_card_model card_u (.run_i(run), .dat3_i(d3), .clk_o(cclk), .dat3_o(cd3));
  initial
    forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (dma === 1'b1)
      n_dma <= n_dma + 1;
  // ****************************************************************
  // Bus, stimulus and check tasks
  // ****************************************************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 50);
    rdat = dout;
    {cyc, stb} <= 2'b00;
    if (t >= 50)
    begin
      n_errors++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic rs;
    rd(cse_pkg::OFF_PRIMARY_STATUS);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fire(input logic [8:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 9'h000;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      {rxw, rxd} <= {1'b1, 32'hA500 | 32'(i)};
    end
    @(posedge clk_i);
    rxw <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    #200000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cse_pkg::OFF_EVENT_MASK);
    chk(rdat, 32'h0);
    rd(cse_pkg::OFF_RESP_WAIT_LIMIT);
    chk(rdat, 32'h0);
    rd(8'h40);
    chk(rdat, 32'h0);
    wb(1'b1, cse_pkg::OFF_BLOCK_COUNT, 32'h3);
    wb(1'b1, cse_pkg::OFF_BLOCKS_REMAINING, 32'h7);
    rd(cse_pkg::OFF_BLOCKS_REMAINING);
    chk(rdat, 32'h3);
    for (int i = 0; i < 9; i++)
    begin
      wb(1'b1, cse_pkg::OFF_COMMAND_ISSUE, {29'h0, tc[i]});
      rs();
      fire(tv[i]);
      rs();
      chk(rdat & {19'h0, ts[i] | tn[i]}, {19'h0, ts[i]});
      rs();
      chk(rdat & {19'h0, ts[i]}, 32'h0);
    end
    busy <= 1'b1;
    wb(1'b1, cse_pkg::OFF_COMMAND_ISSUE, 32'h2);
    fire(9'h020);
    rd(cse_pkg::OFF_SECONDARY_STATUS);
    chk(rdat & 32'h1, 32'h1);
    rs();
    chk(rdat & 32'h2, 32'h0);
    busy <= 1'b0;
    repeat (3) @(posedge clk_i);
    rs();
    chk(rdat & 32'h2, 32'h2);
    wb(1'b1, cse_pkg::OFF_EVENT_MASK, 32'hC28);
    wb(1'b1, cse_pkg::OFF_COMMAND_ISSUE, 32'h1);
    rs();
    fire(9'h018);
    chk({31'h0, irq}, 32'h0);
    fire(9'h002);
    chk({31'h0, irq}, 32'h1);
    rs();
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    fork
      rs();
      fire(9'h001);
    join
    r1 = rdat;
    rs();
    chk((r1 | rdat) & 32'h8, 32'h8);
    d3 <= 1'b1;
    repeat (8) @(posedge clk_i);
    rs();
    chk(rdat & 32'h800, 32'h800);
    halt <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(cse_pkg::OFF_SECONDARY_STATUS);
    chk(rdat & 32'h2, 32'h2);
    wb(1'b1, cse_pkg::OFF_FIFO_SETUP, 32'h0);
    k = n_dma;
    push(9);
    chk(32'(n_dma - k), 32'h1);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      rd(cse_pkg::OFF_RECEIVE_PORT);
      chk(rdat, 32'hA500 | 32'(i));
    end
    chk({31'h0, irq}, 32'h0);
    rs();
    chk(rdat & 32'h400, 32'h0);
    wb(1'b1, cse_pkg::OFF_FIFO_SETUP, 32'h4);
    k = n_dma;
    push(16);
    chk(32'(n_dma - k), 32'h1);
    rbv <= 1'b1;
    @(posedge clk_i);
    rbv <= 1'b0;
    rd(cse_pkg::OFF_SECONDARY_STATUS);
    chk(rdat & 32'h4, 32'h4);
    wb(1'b1, cse_pkg::OFF_COMMAND_ISSUE, 32'h4);
    wb(1'b1, cse_pkg::OFF_FIFO_SETUP, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, txe}, 32'h1);
    rs();
    chk(rdat & 32'h200, 32'h200);
    wb(1'b1, cse_pkg::OFF_TRANSMIT_PORT, 32'h5A);
    repeat (2) @(posedge clk_i);
    chk({31'h0, txe}, 32'h0);
    txt <= 1'b1;
    @(posedge clk_i);
    txt <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, txe}, 32'h1);
    run <= 1'b1;
    for (int l = cse_pkg::ID_SILENCE_CLKS; l >= 0; l -= cse_pkg::ID_SILENCE_CLKS)
    begin
      wb(1'b1, cse_pkg::OFF_RESP_WAIT_LIMIT, 32'(l));
      wb(1'b1, cse_pkg::OFF_COMMAND_ISSUE, 32'h1);
      rs();
      fire(9'h020);
      repeat (8) @(posedge clk_i);
      rs();
      chk(rdat & 32'h10, 32'h0);
      repeat (100) @(posedge clk_i);
      rs();
      chk(rdat & 32'h10, (l != 0) ? 32'h10 : 32'h0);
    end
    run <= 1'b0;
    results();
  end
endmodule
